/* gdio_defs.svh */
// Register offsets, field positions and reset values for the digital I/O port
`ifndef GDIO_DEFS_SVH
`define GDIO_DEFS_SVH

`define GDIO_WIN_AW 5
`define GDIO_OFS_IN_LO 5'h00
`define GDIO_OFS_IN_HI 5'h04
`define GDIO_OFS_OUT_LO 5'h08
`define GDIO_OFS_OUT_HI 5'h0C
`define GDIO_OFS_IRQ_EN 5'h10
`define GDIO_OFS_IRQ_EDGE 5'h14
`define GDIO_OFS_IRQ_STAT 5'h18
`define GDIO_OFS_FILT_CFG 5'h1C

`define GDIO_FILT_EN_BIT 0
`define GDIO_FILT_LEN_LSB 8
`define GDIO_FILT_LEN_W 8

`define GDIO_RST_OUT 64'h0000_0000_0000_0000
`define GDIO_RST_IRQ 16'h0000
`define GDIO_RST_FILT_LEN 8'h00
`define GDIO_RST_RDATA 32'h0000_0000

`endif

/* gdio_edge.sv */
// Edge detection, sticky status and merge for the interrupt-capable inputs
`timescale 1ns/1ns
`default_nettype none
module gdio_edge #(
    parameter int NCH = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [NCH-1:0] lvl_in,
    input wire logic [NCH-1:0] en_in,
    input wire logic [NCH-1:0] sel_in,
    input wire logic [NCH-1:0] clr_in,
    output logic [NCH-1:0] stat_out,
    output logic irq_out
);
    import gdio_pkg::*;
    logic [NCH-1:0] prev_q, stat_q, stat_d, hit;
    logic irq_q, irq_d;

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            // Logic rise is a pin fall; select picks which pin edge counts
            assign hit[i] = (sel_in[i] == GDIO_EDGE_PIN_FALL) ? (lvl_in[i] & ~prev_q[i])
                                                                : (~lvl_in[i] & prev_q[i]);
        end
    endgenerate

    always_comb begin
        // Set beats clear so an edge in the clearing cycle survives
        stat_d = (stat_q & ~clr_in) | (hit & en_in);
        // One shared level for all channels
        irq_d = |(stat_d & en_in);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prev_q <= '0;
            stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            prev_q <= lvl_in;
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    assign stat_out = stat_q;
    assign irq_out = irq_q;
endmodule
`default_nettype wire

/* gdio_field.sv */
// Field wiring: pulled-up lines, external drivers and optional loop-back of the outputs
`timescale 1ns/1ns
`default_nettype none
module gdio_field (
    input wire gdio_pkg::gdio_chan_t dout_pin_in,
    input wire gdio_pkg::gdio_chan_t ext_pin_in,
    input wire logic loop_in,
    output gdio_pkg::gdio_chan_t din_pin_out
);
    import gdio_pkg::*;
    assign din_pin_out = ext_pin_in & (dout_pin_in | {64{!loop_in}});
endmodule
`default_nettype wire

/* gdio_filter.sv */
// One input channel: three-stage synchroniser and chatter filter
`timescale 1ns/1ns
`default_nettype none
module gdio_filter #(
    parameter int CNT_W = 8
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic pin_in,
    input wire logic en_in,
    input wire logic [CNT_W-1:0] len_in,
    output logic val_out
);
    logic s1_q, s2_q, s3_q;
    logic val_q, val_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        val_d = val_q;
        cnt_d = '0;
        // Only agreeing second and third stages count as a change
        if (s2_q == s3_q && s3_q != val_q) begin
            if (!en_in || cnt_q >= len_in) begin
                val_d = s3_q;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            val_q <= 1'b1;
            cnt_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            val_q <= val_d;
            cnt_q <= cnt_d;
        end
    end

    assign val_out = val_q;
endmodule
`default_nettype wire

/* gdio_pkg.sv */
// Shared types for the digital I/O port
package gdio_pkg;
    typedef logic [63:0] gdio_chan_t;
    typedef logic [15:0] gdio_irq_t;
    typedef logic [31:0] gdio_word_t;
    typedef logic [15:5] gdio_base_t;
    typedef enum logic {
        GDIO_EDGE_PIN_FALL,
        GDIO_EDGE_PIN_RISE
    } gdio_edge_e;
endpackage

/* gdio_top.sv */
// Digital I/O port: 64 inverted inputs, 64 inverted outputs, 16 edge interrupts, input filter
// Operation
// - Each of the 64 inputs reads 1 for a low pin and 0 for a high pin.
// - Each of the 64 outputs pulls its pin low for a written 1 and releases it high for a 0.
// - Inputs and outputs share one mapping: value 0 is high level, value 1 is low level.
// - Only inputs 0 to 15 can raise interrupts; the others never do.
// - Each of the sixteen interrupt inputs has its own enable bit.
// - Each interrupt input selects whether a falling or a rising pin edge triggers it.
// - All sixteen requests merge into one active-low interrupt line.
// - A software-set chatter filter sits on every input before reading and edge detection.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "gdio_defs.svh"
module gdio_top #(
    parameter int NIN = 64,
    parameter int NOUT = 64,
    parameter int NIRQ = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire gdio_pkg::gdio_base_t cfg_io_base_in,
    input wire logic [15:0] bus_addr_in,
    input wire gdio_pkg::gdio_word_t bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output gdio_pkg::gdio_word_t bus_rdata_out,
    input wire gdio_pkg::gdio_chan_t din_pin_in,
    output gdio_pkg::gdio_chan_t dout_pin_out,
    output logic intx_n_out
);
    import gdio_pkg::*;

    logic hit;
    logic [`GDIO_WIN_AW-1:0] ofs;
    logic wr, rd;
    gdio_chan_t pin_filt, din_val;
    gdio_chan_t out_q, out_d;
    gdio_chan_t pin_q, pin_d;
    gdio_irq_t en_q, en_d;
    gdio_irq_t sel_q, sel_d;
    gdio_irq_t clr, stat;
    logic filt_en_q, filt_en_d;
    logic [`GDIO_FILT_LEN_W-1:0] filt_len_q, filt_len_d;
    gdio_word_t rdata_q, rdata_d;
    logic irq;
    logic intx_n_q, intx_n_d;

    assign hit = (bus_addr_in[15:`GDIO_WIN_AW] == cfg_io_base_in);
    assign ofs = bus_addr_in[`GDIO_WIN_AW-1:0];
    assign wr = bus_wr_in & hit;
    assign rd = bus_rd_in & hit;

    genvar i;
    generate
        for (i = 0; i < NIN; i++) begin : g_in
            gdio_filter #(
                .CNT_W(`GDIO_FILT_LEN_W)
            ) u_filt (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .pin_in(din_pin_in[i]),
                .en_in(filt_en_q),
                .len_in(filt_len_q),
                .val_out(pin_filt[i])
            );
            assign din_val[i] = ~pin_filt[i];
        end
    endgenerate

    // Only the low sixteen inputs feed interrupts
    gdio_edge #(
        .NCH(NIRQ)
    ) u_edge (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .lvl_in(din_val[NIRQ-1:0]),
        .en_in(en_q),
        .sel_in(sel_q),
        .clr_in(clr),
        .stat_out(stat),
        .irq_out(irq)
    );

    // Status clears by writing one to a bit
    assign clr = (wr && ofs == `GDIO_OFS_IRQ_STAT) ? bus_wdata_in[NIRQ-1:0] : '0;

    always_comb begin
        out_d = out_q;
        en_d = en_q;
        sel_d = sel_q;
        filt_en_d = filt_en_q;
        filt_len_d = filt_len_q;
        if (wr) begin
            unique case (ofs)
                `GDIO_OFS_OUT_LO: out_d[31:0] = bus_wdata_in;
                `GDIO_OFS_OUT_HI: out_d[63:32] = bus_wdata_in;
                `GDIO_OFS_IRQ_EN: en_d = bus_wdata_in[NIRQ-1:0];
                `GDIO_OFS_IRQ_EDGE: sel_d = bus_wdata_in[NIRQ-1:0];
                `GDIO_OFS_FILT_CFG: begin
                    filt_en_d = bus_wdata_in[`GDIO_FILT_EN_BIT];
                    filt_len_d = bus_wdata_in[`GDIO_FILT_LEN_LSB +: `GDIO_FILT_LEN_W];
                end
                default: ;
            endcase
        end
        pin_d = ~out_d;
        intx_n_d = ~irq;
    end

    always_comb begin
        // Unmapped or unaligned reads answer zero
        rdata_d = `GDIO_RST_RDATA;
        if (rd) begin
            unique case (ofs)
                `GDIO_OFS_IN_LO: rdata_d = din_val[31:0];
                `GDIO_OFS_IN_HI: rdata_d = din_val[63:32];
                `GDIO_OFS_OUT_LO: rdata_d = out_q[31:0];
                `GDIO_OFS_OUT_HI: rdata_d = out_q[63:32];
                `GDIO_OFS_IRQ_EN: rdata_d = {16'h0000, en_q};
                `GDIO_OFS_IRQ_EDGE: rdata_d = {16'h0000, sel_q};
                `GDIO_OFS_IRQ_STAT: rdata_d = {16'h0000, stat};
                `GDIO_OFS_FILT_CFG: begin
                    rdata_d[`GDIO_FILT_EN_BIT] = filt_en_q;
                    rdata_d[`GDIO_FILT_LEN_LSB +: `GDIO_FILT_LEN_W] = filt_len_q;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            out_q <= `GDIO_RST_OUT;
            pin_q <= ~`GDIO_RST_OUT;
            en_q <= `GDIO_RST_IRQ;
            sel_q <= `GDIO_RST_IRQ;
            filt_en_q <= 1'b0;
            filt_len_q <= `GDIO_RST_FILT_LEN;
            rdata_q <= `GDIO_RST_RDATA;
            intx_n_q <= 1'b1;
        end else begin
            out_q <= out_d;
            pin_q <= pin_d;
            en_q <= en_d;
            sel_q <= sel_d;
            filt_en_q <= filt_en_d;
            filt_len_q <= filt_len_d;
            rdata_q <= rdata_d;
            intx_n_q <= intx_n_d;
        end
    end

    assign bus_rdata_out = rdata_q;
    assign dout_pin_out = pin_q;
    assign intx_n_out = intx_n_q;
endmodule
`default_nettype wire

/* gdio_top_properties.sv */
// Concurrent checks on the digital I/O port bus, outputs and interrupt line
`timescale 1ns/1ns
`default_nettype none
`include "gdio_defs.svh"
module gdio_top_chk (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire gdio_pkg::gdio_base_t cfg_io_base_in,
    input wire logic [15:0] bus_addr_in,
    input wire gdio_pkg::gdio_word_t bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire gdio_pkg::gdio_word_t bus_rdata_out,
    input wire gdio_pkg::gdio_chan_t dout_pin_out,
    input wire logic intx_n_out
);
    import gdio_pkg::*;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    logic hit;
    logic [4:0] ofs;
    assign hit = bus_addr_in[15:5] == cfg_io_base_in;
    assign ofs = bus_addr_in[4:0];
    property p_rd_idle;
        !$past(bus_rd_in) |-> bus_rdata_out == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_rst;
        disable iff (1'b0) sys_rst_in |=> dout_pin_out == '1 && intx_n_out && bus_rdata_out == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    // Pin register takes the inverted written value one edge after the strobe
    property p_out_lo;
        bus_wr_in && hit && ofs == `GDIO_OFS_OUT_LO |=> dout_pin_out[31:0] == ~$past(bus_wdata_in);
    endproperty
    a_out_lo: assert property (p_out_lo) else $error("out low pins");
    property p_out_hi;
        bus_wr_in && hit && ofs == `GDIO_OFS_OUT_HI |=> dout_pin_out[63:32] == ~$past(bus_wdata_in);
    endproperty
    a_out_hi: assert property (p_out_hi) else $error("out high pins");
    property p_rd_out;
        bus_rd_in && hit && ofs == `GDIO_OFS_OUT_LO |=> bus_rdata_out == ~dout_pin_out[31:0];
    endproperty
    a_rd_out: assert property (p_rd_out) else $error("out readback");
    property p_miss;
        bus_rd_in && !hit |=> bus_rdata_out == '0;
    endproperty
    a_miss: assert property (p_miss) else $error("miss read");
    // Old enable still gates the merge flop one edge, then the line flop adds one
    property p_mask;
        bus_wr_in && hit && ofs == `GDIO_OFS_IRQ_EN && bus_wdata_in[15:0] == '0 |-> ##3 intx_n_out;
    endproperty
    a_mask: assert property (p_mask) else $error("mask");
    // Line is only released by a write: a status clear or a mask one edge later
    property p_release;
        $rose(intx_n_out) |-> $past(bus_wr_in, 2) || $past(bus_wr_in, 3);
    endproperty
    a_release: assert property (p_release) else $error("release");
endmodule
bind gdio_top gdio_top_chk u_gdio_top_chk (.clk_in, .sys_rst_in, .cfg_io_base_in, .bus_addr_in, .bus_wdata_in,
    .bus_wr_in, .bus_rd_in, .bus_rdata_out, .dout_pin_out, .intx_n_out);
`default_nettype wire

/* tb_top.sv */
// Directed register-level tests of the digital I/O port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gdio_pkg::*;
    localparam logic [15:0] BASE = 16'h0400;
    logic clk_in = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic loop = 1'b0;
    logic irq_n;
    logic [15:0] addr = 16'h0000;
    gdio_word_t wdata = 32'h0;
    gdio_word_t rdata;
    gdio_chan_t ext = '1;
    gdio_chan_t din;
    gdio_chan_t dout;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    gdio_top u_gdio_top (.clk_in(clk_in), .sys_rst_in(rst), .cfg_io_base_in(BASE[15:5]), .bus_addr_in(addr),
        .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .din_pin_in(din),
        .dout_pin_out(dout), .intx_n_out(irq_n));
    gdio_field u_gdio_field (.dout_pin_in(dout), .ext_pin_in(ext), .loop_in(loop), .din_pin_out(din));
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input gdio_word_t d);
        @(posedge clk_in);
        addr <= BASE + a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input string nm, input logic [15:0] a, input gdio_word_t exp);
        @(posedge clk_in);
        addr <= BASE + a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(nm, rdata, exp);
    endtask
    task automatic wait_chk_irq(input logic exp);
        repeat (10) @(posedge clk_in);
        #1 chk("irq_n", irq_n, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // Ceiling well above the under two hundred cycles the tests need
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst <= 1'b0;
        #1 chk("dout", dout, '1);
        rd_reg("out_lo", 16'h08, 32'h0);
        wr_reg(16'h08, 32'hA5A5_0F0F);
        wr_reg(16'h0C, 32'h1234_5678);
        wr_reg(16'h28, 32'hFFFF_FFFF);
        rd_reg("out_hi", 16'h0C, 32'h1234_5678);
        chk("dout", dout, ~64'h1234_5678_A5A5_0F0F);
        rd_reg("miss", 16'h28, 32'h0);
        loop <= 1'b1;
        repeat (8) @(posedge clk_in);
        rd_reg("in_lo", 16'h00, 32'hA5A5_0F0F);
        rd_reg("in_hi", 16'h04, 32'h1234_5678);
        loop <= 1'b0;
        $display("io test done");
        wr_reg(16'h10, 32'h1);
        wr_reg(16'h14, 32'h0);
        ext[0] <= 1'b0;
        wait_chk_irq(1'b0);
        rd_reg("stat", 16'h18, 32'h1);
        wr_reg(16'h18, 32'h1);
        wait_chk_irq(1'b1);
        wr_reg(16'h14, 32'h1);
        rd_reg("edge", 16'h14, 32'h1);
        ext[0] <= 1'b1;
        wait_chk_irq(1'b0);
        wr_reg(16'h10, 32'h0);
        wait_chk_irq(1'b1);
        wr_reg(16'h18, 32'hFFFF);
        wr_reg(16'h10, 32'hFFFF);
        rd_reg("en", 16'h10, 32'h0000_FFFF);
        ext[63:16] <= '0;
        wait_chk_irq(1'b1);
        rd_reg("stat", 16'h18, 32'h0);
        $display("irq test done");
        wr_reg(16'h10, 32'h0);
        wr_reg(16'h1C, 32'h0000_0801);
        rd_reg("filt", 16'h1C, 32'h0000_0801);
        ext <= '1;
        repeat (20) @(posedge clk_in);
        ext[1] <= 1'b0;
        repeat (3) @(posedge clk_in);
        ext[1] <= 1'b1;
        repeat (20) @(posedge clk_in);
        rd_reg("glitch", 16'h00, 32'h0);
        ext[1] <= 1'b0;
        repeat (20) @(posedge clk_in);
        rd_reg("held", 16'h00, 32'h2);
        $display("filter test done");
        end_of_test();
    end
endmodule
`default_nettype wire
